// file: verilog/ccd_fe_pkg.sv
`default_nettype none
package ccd_fe_pkg;

	localparam int          SAMPLE_W        = 12;
	localparam int          SER_BITS        = 16;
	localparam logic [4:0]  SER_WORD_LEN    = 5'h10;
	localparam int          SCK_MAX_MHZ     = 5;

	// Register select codes carried in the three lowest bits of a word
	localparam logic [2:0]  REG_GAIN        = 3'h0;
	localparam logic [2:0]  REG_POWER       = 3'h1;
	localparam logic [2:0]  REG_CLAMP       = 3'h2;
	localparam logic [2:0]  REG_BIAS        = 3'h3;
	localparam int          SEL_MSB         = 2;
	localparam logic [15:0] REG_RESET_VAL   = 16'h0000;

	// Register 0 fields
	localparam int          GAIN_LSB        = 3;
	localparam int          GAIN_MSB        = 12;
	localparam int          LUMA_SEL_BIT    = 14;
	localparam int          CHROMA_SEL_BIT  = 15;
	// Register 1 fields
	localparam int          SLEEP_BIT       = 3;
	localparam int          STANDBY_BIT     = 4;
	localparam int          CODE_A_BIT      = 5;
	localparam int          CODE_B_BIT      = 6;
	localparam int          CODE_C_BIT      = 7;
	localparam int          SHA_BW_LSB      = 8;
	localparam int          SHA_BW_MSB      = 9;
	localparam int          HOLD_TC_LSB     = 10;
	localparam int          HOLD_TC_MSB     = 13;
	// Register 2 fields
	localparam int          CLAMP_LVL_LSB   = 3;
	localparam int          CLAMP_LVL_MSB   = 7;
	localparam int          CANCEL_LSB      = 8;
	localparam int          CANCEL_MSB      = 9;
	localparam int          GAIN_MULT_LSB   = 10;
	localparam int          GAIN_MULT_MSB   = 11;
	localparam int          LOW_POWER_BIT   = 12;
	localparam int          SP_INV_BIT      = 13;
	localparam int          OB_INV_BIT      = 14;
	localparam int          RUN_BIT         = 15;
	// Register 3 fields
	localparam int          BIAS_OFF_BIT    = 3;
	localparam int          CODE_D_BIT      = 4;
	localparam int          FOUR_AVG_BIT    = 6;
	localparam logic [15:0] BIAS_TEST_MASK  = 16'hFC00;
	localparam logic [15:0] BIAS_TEST_DEF   = 16'h9000;

	// Datapath timing in conversion-clock cycles
	localparam int          LAT_CDS         = 12;
	localparam int          LAT_DIRECT      = 11;
	localparam logic [3:0]  OB_WIN_FIRST    = 4'h5;
	localparam logic [3:0]  OB_WIN_LAST     = 4'hC;
	localparam int          OB_AVG_SHIFT    = 3;
	localparam int          LINE_AVG_SHIFT  = 2;

	typedef struct packed {
		logic       direct;
		logic       inv_sp;
		logic       inv_ob;
		logic       code_a;
		logic       code_b;
		logic       code_c;
		logic       code_d;
		logic       sleep;
		logic       standby;
		logic       four_avg;
		logic       run;
		logic [4:0] clamp_lvl;
	} conv_cfg_t;

	typedef struct packed {
		logic black;
		logic signal;
		logic preblank;
	} sample_strobes_t;

endpackage
`default_nettype wire

// file: verilog/ccd_fe_ctrl.sv
// Behaviour
// RL1: Sample output changes on conversion clock rise
// RL2: Latency twelve cycles correlated, eleven direct
// RL3: Direct mode samples input on rising edge
// RL4: Cycles five to twelve after pulse: window
// RL5: Eight window samples averaged into clamp reference
// RL6: Output enable bar high floats all outputs; code only raises DOUT_OE_N, which covers DOUT_O alone
// RL7: Low three bits select register; 4-7 test
// RL8: Register 0 bits 3-12 hold gain
// RL9: Register 0 bits 14/15 choose input path
// RL10: Sleep stops everything; standby keeps reference only
// RL11: Four bits select alternative output coding
// RL12: Register 1 holds bandwidth and hold constant
// RL13: Register 2 holds lead-in time and gain
// RL14: Register 2 bit 12 selects low power
// RL15: Inversion bit flips sample and preblank pulses
// RL16: Register 2 bit 15 low: reset, test defaults
// RL17: Register 3 bias off and four-line average
// RL18: Controller writes test bits with fixed values
// RL19: Data line captured on serial clock rise
// RL20: Controller sends exactly sixteen clocks per word
// RL21: Aborted word leaves registers unchanged
// RL22: Serial clock at most five megahertz
// RL23: LSB first, applied when select returns high
`timescale 1ns/1ns
`default_nettype none
module ccd_fe_ctrl
	import ccd_fe_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	input  wire logic                  CONVERSION_CLOCK,
	input  wire logic                  SERIAL_CLOCK,
	input  wire logic                  CHIP_SELECT_N,
	input  wire logic                  SERIAL_DATA_IN,
	input  wire logic                  OPTICAL_BLACK_PULSE,
	input  wire logic                  BLACK_SAMPLE_PULSE,
	input  wire logic                  SIGNAL_SAMPLE_PULSE,
	input  wire logic                  PREBLANK_INPUT,
	input  wire logic                  OUTPUT_ENABLE_BAR,
	input  wire logic [SAMPLE_W-1:0]   SAMPLE_IN,
	output logic      [SAMPLE_W-1:0]   DOUT_O,
	output logic                       DOUT_OE_N,
	output logic      [SAMPLE_W-1:0]   CLAMP_REF,
	output sample_strobes_t            SAMPLE_STROBES,
	output logic      [9:0]            GAIN_SETTING,
	output logic                       LUMA_INPUT_SELECT,
	output logic                       CHROMA_INPUT_SELECT,
	output logic      [1:0]            SHA_BW_SEL,
	output logic      [3:0]            BLACK_HOLD_TC_SEL,
	output logic      [1:0]            LEADIN_CANCEL_TIME,
	output logic      [1:0]            LEADIN_GAIN_MULT,
	output logic                       LOW_POWER_SELECT,
	output logic                       LUMA_CHROMA_BIAS_OFF,
	output logic                       REF_ENABLE,
	output logic                       CORE_ENABLE
);

	logic        sck_s1, sck_s2, sck_s3;
	logic        cs_s1, cs_s2, cs_s3;
	logic        sd_s1, sd_s2;
	logic        sck_rise, cs_rise;
	logic [15:0] shift_q;
	logic [4:0]  bit_cnt_q;
	logic [15:0] regs_q [4];
	logic        word_ok;
	conv_cfg_t   cfg_w, shadow_q;
	logic        req_q, ack_s1, ack_s2, ack_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			cs_s3  <= 1'b1;
			sd_s1  <= 1'b0;
			sd_s2  <= 1'b0;
		end else if (CE) begin
			sck_s1 <= SERIAL_CLOCK;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			cs_s1  <= CHIP_SELECT_N;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			sd_s1  <= SERIAL_DATA_IN;
			sd_s2  <= sd_s1;
		end
	end

	// Oversampling works because the serial clock is far slower than CLK
	assign sck_rise = sck_s2 & ~sck_s3;
	assign cs_rise  = cs_s2 & ~cs_s3;

	always_ff @(posedge CLK) begin
		if (RST) begin
			shift_q   <= 16'h0000;
			bit_cnt_q <= 5'h00;
		end else if (CE) begin
			if (cs_s2) begin
				bit_cnt_q <= 5'h00;
			end else if (sck_rise) begin
				shift_q <= {sd_s2, shift_q[15:1]};                 // RL19 RL23
				if (bit_cnt_q != 5'h1F) begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
				end
			end
		end
	end

	// Short or long words are both dropped; test codes never land
	assign word_ok = cs_rise && (bit_cnt_q == SER_WORD_LEN)             // RL21
		&& !shift_q[SEL_MSB];                                       // RL7

	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < 4; i++) begin
				regs_q[i] <= REG_RESET_VAL;
			end
		end else if (CE) begin
			if (word_ok) begin
				regs_q[shift_q[1:0]] <= shift_q;                   // RL23
			end
			if (!regs_q[REG_CLAMP[1:0]][RUN_BIT]) begin
				regs_q[REG_BIAS[1:0]] <= (regs_q[REG_BIAS[1:0]]
					& ~BIAS_TEST_MASK) | BIAS_TEST_DEF;          // RL16
			end
		end
	end

	always_comb begin
		cfg_w.direct    = regs_q[0][LUMA_SEL_BIT]
			| regs_q[0][CHROMA_SEL_BIT];                       // RL9
		cfg_w.inv_sp    = regs_q[2][SP_INV_BIT];
		cfg_w.inv_ob    = regs_q[2][OB_INV_BIT];
		cfg_w.code_a    = regs_q[1][CODE_A_BIT];
		cfg_w.code_b    = regs_q[1][CODE_B_BIT];
		cfg_w.code_c    = regs_q[1][CODE_C_BIT];
		cfg_w.code_d    = regs_q[3][CODE_D_BIT];
		cfg_w.sleep     = regs_q[1][SLEEP_BIT];
		cfg_w.standby   = regs_q[1][STANDBY_BIT];
		cfg_w.four_avg  = regs_q[3][FOUR_AVG_BIT];
		cfg_w.run       = regs_q[2][RUN_BIT];
		cfg_w.clamp_lvl = regs_q[2][CLAMP_LVL_MSB:CLAMP_LVL_LSB];
	end

	assign GAIN_SETTING         = regs_q[0][GAIN_MSB:GAIN_LSB];        // RL8
	assign LUMA_INPUT_SELECT    = regs_q[0][LUMA_SEL_BIT];
	assign CHROMA_INPUT_SELECT  = regs_q[0][CHROMA_SEL_BIT];
	assign SHA_BW_SEL           = regs_q[1][SHA_BW_MSB:SHA_BW_LSB];    // RL12
	assign BLACK_HOLD_TC_SEL    = regs_q[1][HOLD_TC_MSB:HOLD_TC_LSB];  // RL12
	assign LEADIN_CANCEL_TIME   = regs_q[2][CANCEL_MSB:CANCEL_LSB];    // RL13
	assign LEADIN_GAIN_MULT     = regs_q[2][GAIN_MULT_MSB:GAIN_MULT_LSB]; // RL13
	assign LOW_POWER_SELECT     = regs_q[2][LOW_POWER_BIT];            // RL14
	assign LUMA_CHROMA_BIAS_OFF = regs_q[3][BIAS_OFF_BIT];             // RL17
	assign REF_ENABLE           = ~regs_q[1][SLEEP_BIT];               // RL10
	assign CORE_ENABLE          = ~regs_q[1][SLEEP_BIT]
		& ~regs_q[1][STANDBY_BIT];                                 // RL10

	// Shadow stays frozen while a handover is in flight
	always_ff @(posedge CLK) begin
		if (RST) begin
			shadow_q <= '0;
			req_q    <= 1'b0;
			ack_s1   <= 1'b0;
			ack_s2   <= 1'b0;
		end else if (CE) begin
			ack_s1 <= ack_q;
			ack_s2 <= ack_s1;
			if (req_q == ack_s2 && shadow_q != cfg_w) begin
				shadow_q <= cfg_w;
				req_q    <= ~req_q;
			end
		end
	end

	logic                rst_c1, rst_c2, ce_c1, ce_c2;
	logic                req_c1, req_c2;
	logic                oe_bar_s1, oe_bar_s2;
	conv_cfg_t           cfg_c;
	logic                dp_clr, adv;
	logic [SAMPLE_W-1:0] pipe_q [LAT_CDS-1];
	logic [SAMPLE_W-1:0] tap_w, corr_w, dout_q, avg_q, ref_w;
	logic [13:0]         diff_w;
	logic                obp_eff, ob_prev_q, ob_rise, ob_win;
	logic [3:0]          ob_cnt_q;
	logic [14:0]         ob_sum_q, ob_sum_w;
	logic [SAMPLE_W-1:0] line_q [4];
	logic [13:0]         line_sum_w;
	logic                oe_n_q;
	sample_strobes_t     strobe_q;

	always_ff @(posedge CONVERSION_CLOCK) begin
		rst_c1 <= RST;
		rst_c2 <= rst_c1;
		ce_c1  <= CE;
		ce_c2  <= ce_c1;
	end

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (rst_c2) begin
			req_c1 <= 1'b0;
			req_c2 <= 1'b0;
			ack_q  <= 1'b0;
			cfg_c  <= '0;
		end else if (ce_c2) begin
			req_c1 <= req_q;
			req_c2 <= req_c1;
			if (req_c2 != ack_q) begin
				cfg_c <= shadow_q;
			end
			ack_q <= req_c2;
		end
	end

	assign dp_clr = rst_c2 || !cfg_c.run;                              // RL16
	assign adv    = ce_c2 && !cfg_c.sleep && !cfg_c.standby;           // RL10

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (dp_clr) begin
			for (int i = 0; i < LAT_CDS - 1; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (adv) begin
			pipe_q[0] <= SAMPLE_IN;                                    // RL3
			for (int i = 1; i < LAT_CDS - 1; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	// One tap earlier in direct mode; output register adds the last stage
	assign tap_w = cfg_c.direct ? pipe_q[LAT_DIRECT-2]
		: pipe_q[LAT_CDS-2];                                       // RL2

	assign obp_eff = OPTICAL_BLACK_PULSE ^ cfg_c.inv_ob;
	assign ob_rise = obp_eff && !ob_prev_q;
	assign ob_win  = ob_cnt_q >= OB_WIN_FIRST && ob_cnt_q <= OB_WIN_LAST; // RL4
	assign ob_sum_w = ob_sum_q + {3'h0, pipe_q[0]};

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (dp_clr) begin
			ob_prev_q <= 1'b0;
			ob_cnt_q  <= 4'h0;
			ob_sum_q  <= 15'h0000;
			avg_q     <= '0;
		end else if (adv) begin
			ob_prev_q <= obp_eff;
			if (ob_rise) begin
				ob_cnt_q <= 4'h1;                                  // RL4
				ob_sum_q <= 15'h0000;
			end else if (ob_cnt_q == OB_WIN_LAST) begin
				ob_cnt_q <= 4'h0;
				ob_sum_q <= 15'h0000;
				avg_q    <= ob_sum_w[OB_AVG_SHIFT +: SAMPLE_W];     // RL5
			end else begin
				if (ob_cnt_q != 4'h0) begin
					ob_cnt_q <= ob_cnt_q + 4'h1;
				end
				if (ob_win) begin
					ob_sum_q <= ob_sum_w;                          // RL5
				end
			end
		end
	end

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (dp_clr) begin
			for (int i = 0; i < 4; i++) begin
				line_q[i] <= '0;
			end
		end else if (adv && !ob_rise && ob_cnt_q == OB_WIN_LAST) begin
			line_q[0] <= ob_sum_w[OB_AVG_SHIFT +: SAMPLE_W];
			for (int i = 1; i < 4; i++) begin
				line_q[i] <= line_q[i-1];
			end
		end
	end

	// History starts at zero, so the four-line reference ramps in
	assign line_sum_w = {2'h0, line_q[0]} + {2'h0, line_q[1]}
		+ {2'h0, line_q[2]} + {2'h0, line_q[3]};
	assign ref_w = cfg_c.four_avg ? line_sum_w[LINE_AVG_SHIFT +: SAMPLE_W]
		: avg_q;                                                   // RL17

	assign diff_w = {2'h0, tap_w} - {2'h0, ref_w} + {9'h000, cfg_c.clamp_lvl};
	always_comb begin
		if (cfg_c.direct) begin
			corr_w = tap_w;
		end else if (diff_w[13]) begin
			corr_w = '0;
		end else if (diff_w[12]) begin
			corr_w = '1;
		end else begin
			corr_w = diff_w[SAMPLE_W-1:0];
		end
	end

	function automatic logic [SAMPLE_W-1:0] encode(
		input logic [SAMPLE_W-1:0] x,
		input conv_cfg_t           c
	);
		logic [SAMPLE_W-1:0] y;
		y = x;
		if (c.code_c || c.code_d) begin
			y = y ^ (y >> 1);
		end
		if (c.code_a) begin
			y = ~y;
		end
		if (c.code_b) begin
			y[SAMPLE_W-1] = ~y[SAMPLE_W-1];
		end
		return y;
	endfunction

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (dp_clr) begin
			dout_q <= '0;
		end else if (ce_c2) begin
			if (cfg_c.sleep) begin
				dout_q <= '0;
			end else if (adv) begin
				dout_q <= encode(corr_w, cfg_c);                   // RL1 RL11
			end
		end
	end

	always_ff @(posedge CONVERSION_CLOCK) begin
		if (rst_c2) begin
			oe_bar_s1 <= 1'b1;
			oe_bar_s2 <= 1'b1;
			oe_n_q    <= 1'b1;
			strobe_q  <= '0;
		end else if (ce_c2) begin
			oe_bar_s1 <= OUTPUT_ENABLE_BAR;
			oe_bar_s2 <= oe_bar_s1;
			oe_n_q    <= oe_bar_s2;                                 // RL6
			strobe_q  <= {BLACK_SAMPLE_PULSE, SIGNAL_SAMPLE_PULSE,
				PREBLANK_INPUT} ^ {3{cfg_c.inv_sp}};               // RL15
		end
	end

	assign DOUT_O         = dout_q;
	assign DOUT_OE_N      = oe_n_q;
	assign CLAMP_REF      = ref_w;
	assign SAMPLE_STROBES = strobe_q;

	logic [3:0] run_cnt_q;
	always_ff @(posedge CONVERSION_CLOCK) begin
		if (dp_clr || !adv || req_c2 != ack_q) begin
			run_cnt_q <= 4'h0;
		end else if (run_cnt_q != 4'hF) begin
			run_cnt_q <= run_cnt_q + 4'h1;
		end
	end

	a_latency_cds: assert property (@(posedge CONVERSION_CLOCK) disable iff (rst_c2) // RL2
		(run_cnt_q >= 4'hC && !cfg_c.direct) |-> tap_w == $past(SAMPLE_IN, 11))
		else $error("correlated-mode pipeline tap misaligned");
	a_latency_direct: assert property (@(posedge CONVERSION_CLOCK) disable iff (rst_c2) // RL2
		(run_cnt_q >= 4'hC && cfg_c.direct) |-> tap_w == $past(SAMPLE_IN, 10))
		else $error("direct-mode pipeline tap misaligned");
	a_output_update: assert property (@(posedge CONVERSION_CLOCK) disable iff (rst_c2) // RL1
		(adv && !dp_clr && !cfg_c.sleep)
		|=> dout_q == encode($past(corr_w), $past(cfg_c)))
		else $error("sample output not updated on conversion edge");
	a_ob_window: assert property (@(posedge CONVERSION_CLOCK) disable iff (dp_clr) // RL4
		(ob_rise && adv) ##1 (adv && !ob_rise) [*4] |=> ob_win && ob_cnt_q == 4'h5)
		else $error("black window did not open on fifth cycle");
	a_ob_average: assert property (@(posedge CONVERSION_CLOCK) disable iff (dp_clr) // RL5
		(adv && !ob_rise && ob_cnt_q == OB_WIN_LAST) |=>
		avg_q == $past(ob_sum_w[OB_AVG_SHIFT +: SAMPLE_W]) && ob_cnt_q == 4'h0)
		else $error("clamp reference not the window average");
	a_float_out: assert property (@(posedge CONVERSION_CLOCK) disable iff (rst_c2) // RL6
		(ce_c2 && oe_bar_s2) |=> DOUT_OE_N)
		else $error("outputs driven while enable bar high");
	a_sleep_zero: assert property (@(posedge CONVERSION_CLOCK) disable iff (rst_c2) // RL10
		(ce_c2 && cfg_c.sleep) |=> dout_q == '0 && $stable(pipe_q[0]))
		else $error("datapath active during sleep");
	a_serial_shift: assert property (@(posedge CLK) disable iff (RST) // RL19
		(CE && sck_rise && !cs_s2) |=> shift_q[15] == $past(sd_s2))
		else $error("serial bit not captured on clock rise");
	a_serial_abort: assert property (@(posedge CLK) disable iff (RST) // RL21
		(CE && cs_rise && bit_cnt_q != SER_WORD_LEN && regs_q[2][RUN_BIT])
		|=> $stable(regs_q[0]) && $stable(regs_q[1]) && $stable(regs_q[2])
		&& $stable(regs_q[3]))
		else $error("aborted serial word changed a register");
	a_serial_apply: assert property (@(posedge CLK) disable iff (RST) // RL23
		(CE && word_ok && shift_q[1:0] == 2'h0) |=> regs_q[0] == $past(shift_q))
		else $error("complete word not applied at select release");
	a_test_codes: assert property (@(posedge CLK) disable iff (RST) // RL7
		(CE && cs_rise && shift_q[SEL_MSB]) |=> $stable(regs_q[0]) && $stable(regs_q[1]))
		else $error("test register code wrote a user register");
	a_reset_defaults: assert property (@(posedge CLK) disable iff (RST) // RL16
		(CE && !regs_q[2][RUN_BIT]) ##1 CE |=>
		(regs_q[3] & BIAS_TEST_MASK) == BIAS_TEST_DEF)
		else $error("test bits not forced in reset mode");

	c_ob_cycle: cover property (@(posedge CONVERSION_CLOCK) disable iff (dp_clr)
		adv && ob_cnt_q == OB_WIN_LAST);
	c_direct_run: cover property (@(posedge CONVERSION_CLOCK) disable iff (dp_clr)
		cfg_c.direct && run_cnt_q == 4'hF);
	c_word_apply: cover property (@(posedge CLK) disable iff (RST) word_ok);
	c_word_abort: cover property (@(posedge CLK) disable iff (RST)
		cs_rise && bit_cnt_q != SER_WORD_LEN && bit_cnt_q != 5'h00);

endmodule
`default_nettype wire

// file: sim/ccd_cam_host.sv
`timescale 1ns/1ns
`default_nettype none
module ccd_cam_host (
	input  wire logic CLK,
	output logic      SCK,
	output logic      CS_N,
	output logic      SDI
);
	// 13 CLK cycles per half period keeps the serial clock under 5 MHz
	localparam int HALF = 13;

	initial begin
		SCK = 1'b0;
		CS_N = 1'b1;
		SDI = 1'b0;
	end

	// One bit per serial clock rise, LSB first, select held low throughout
	task automatic send(input logic [16:0] w, input int n);
		int i;
		@(negedge CLK);
		CS_N = 1'b0;
		for (i = 0; i < n; i++) begin
			SDI = w[i];
			repeat (HALF) @(negedge CLK);
			SCK = 1'b1;
			repeat (HALF) @(negedge CLK);
			SCK = 1'b0;
		end
		repeat (HALF) @(negedge CLK);
		CS_N = 1'b1;
		// Released line shows the inverse so a stale bit cannot pass
		SDI = ~SDI;
		repeat (HALF) @(negedge CLK);
	endtask
endmodule
`default_nettype wire

// file: sim/ccd_frontend_ctrl_and_output_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ccd_frontend_ctrl_and_output_tb;
	import ccd_fe_pkg::*;
	logic                clk, cclk, rst, ce, ob, spb, sps, pb, oe_bar;
	logic [SAMPLE_W-1:0] sin, dout, cref;
	logic                oe_n, luma, chroma, lowpwr, bias_off, ref_en, core_en;
	logic [9:0]          gain;
	logic [1:0]          sha_bw, cancel, gmult;
	logic [3:0]          hold_tc;
	sample_strobes_t     strb;
	wire                 sck, cs_n, sdi;
	wire  [SAMPLE_W-1:0] dout_pin;
	int                  error_cnt, check_count;

	// Pins float when the enable is off
	assign dout_pin = oe_n ? 12'hZZZ : dout;

	ccd_fe_ctrl dut (.CLK(clk), .RST(rst), .CE(ce), .CONVERSION_CLOCK(cclk),
		.SERIAL_CLOCK(sck), .CHIP_SELECT_N(cs_n), .SERIAL_DATA_IN(sdi),
		.OPTICAL_BLACK_PULSE(ob), .BLACK_SAMPLE_PULSE(spb),
		.SIGNAL_SAMPLE_PULSE(sps), .PREBLANK_INPUT(pb),
		.OUTPUT_ENABLE_BAR(oe_bar), .SAMPLE_IN(sin), .DOUT_O(dout),
		.DOUT_OE_N(oe_n), .CLAMP_REF(cref), .SAMPLE_STROBES(strb),
		.GAIN_SETTING(gain), .LUMA_INPUT_SELECT(luma),
		.CHROMA_INPUT_SELECT(chroma), .SHA_BW_SEL(sha_bw),
		.BLACK_HOLD_TC_SEL(hold_tc), .LEADIN_CANCEL_TIME(cancel),
		.LEADIN_GAIN_MULT(gmult), .LOW_POWER_SELECT(lowpwr),
		.LUMA_CHROMA_BIAS_OFF(bias_off), .REF_ENABLE(ref_en),
		.CORE_ENABLE(core_en));

	ccd_cam_host host (.CLK(clk), .SCK(sck), .CS_N(cs_n), .SDI(sdi));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Phase offset keeps the two domains unrelated
	initial begin
		cclk = 1'b0;
		#1;
		forever #3 cclk = ~cclk;
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Settle time covers the two-flop path and the register update
	task automatic wr(input logic [15:0] w);
		host.send({1'b0, w}, 16);
		repeat (6) @(negedge clk);
	endtask

	task automatic cwait(input int n);
		repeat (n) @(negedge cclk);
	endtask

	// Counts conversion edges from capture until the marker appears
	task automatic lat(input logic [11:0] m, input logic [11:0] e,
		input int n);
		int k;
		@(negedge cclk);
		sin = m;
		for (k = 1; k <= 20; k++) begin
			@(negedge cclk);
			sin = 12'h000;
			if (dout === e)
				break;
		end
		check("latency", k[15:0], n[15:0]);
	endtask

	task automatic t_regs;
		wr(16'h9602);
		check("cancel", cancel, 2'h2);
		check("gmult", gmult, 2'h1);
		check("lowpwr", lowpwr, 1'h1);
		wr(16'h5528);
		check("gain", gain, 10'h2A5);
		check("luma", luma, 1'h1);
		check("chroma", chroma, 1'h0);
		wr(16'h2B01);
		check("sha_bw", sha_bw, 2'h3);
		check("hold_tc", hold_tc, 4'hA);
		wr(16'h2B09);
		check("ref_sleep", ref_en, 1'h0);
		check("core_sleep", core_en, 1'h0);
		wr(16'h2B11);
		check("ref_standby_bit", ref_en, 1'h1);
		check("core_standby_bit", core_en, 1'h0);
		wr(16'h2B01);
		check("core_run", core_en, 1'h1);
		wr(16'h900B);
		check("bias_off", bias_off, 1'h1);
	endtask

	task automatic t_refuse;
		host.send(17'h00004, 16);
		host.send(17'h00000, 15);
		host.send(17'h00000, 17);
		repeat (6) @(negedge clk);
		check("gain_kept", gain, 10'h2A5);
		check("luma_kept", luma, 1'h1);
	endtask

	// Clock enable low freezes the serial front end, so the word is lost
	task automatic t_freeze;
		ce = 1'b0;
		host.send(17'h00000, 16);
		ce = 1'b1;
		repeat (6) @(negedge clk);
		check("gain_frozen", gain, 10'h2A5);
		check("luma_frozen", luma, 1'h1);
	endtask

	task automatic t_direct;
		cwait(20);
		lat(12'h300, 12'h300, 11);
		wr(16'h2B21);
		cwait(20);
		lat(12'h300, 12'hCFF, 11);
		wr(16'h2B41);
		cwait(20);
		lat(12'h300, 12'hB00, 11);
		wr(16'h2B81);
		cwait(20);
		lat(12'h300, 12'h280, 11);
		wr(16'h2B01);
	endtask

	// Black level stands in exactly the eight window cycles; a shift skews it
	task automatic t_cds;
		int j;
		wr(16'h1528);
		cwait(20);
		ob = 1'b1;
		for (j = 1; j <= 16; j++) begin
			@(negedge cclk);
			ob = 1'b0;
			sin = (j >= 4 && j <= 11) ? 12'h080 : 12'h000;
		end
		cwait(8);
		check("clamp_ref", cref, 12'h080);
		lat(12'h300, 12'h280, 12);
	endtask

	task automatic t_oe;
		cwait(1);
		oe_bar = 1'b1;
		cwait(5);
		check("oe_n_off", oe_n, 1'h1);
		check("pins_float", dout_pin, 12'hZZZ);
		oe_bar = 1'b0;
		cwait(5);
		check("oe_n_on", oe_n, 1'h0);
	endtask

	task automatic t_strobe;
		wr(16'hB602);
		cwait(10);
		spb = 1'b1;
		pb = 1'b1;
		cwait(4);
		check("strb_inv", strb, 3'h2);
		wr(16'h9602);
		cwait(10);
		check("strb_plain", strb, 3'h5);
	endtask

	initial begin
		error_cnt = 0;
		check_count = 0;
		rst = 1'b1;
		ob = 1'b0;
		spb = 1'b0;
		sps = 1'b0;
		pb = 1'b0;
		oe_bar = 1'b0;
		ce = 1'b1;
		sin = 12'h000;
		repeat (8) @(negedge clk);
		check("ref_rst", ref_en, 1'h1);
		check("gain_rst", gain, 10'h000);
		check("oe_n_rst", oe_n, 1'h1);
		rst = 1'b0;
		t_regs;
		t_refuse;
		t_freeze;
		t_direct;
		t_cds;
		t_oe;
		t_strobe;
		end_sim;
	end
endmodule
`default_nettype wire
